// ---- buffered_uart.sv ----
// Contract
// - Bit rate must lie in 9600..230400 bps, otherwise rejected as out of range.
// - Character length is five, six, seven or eight bits; other codes rejected.
// - Parity none, odd, even, mark or space; none adds no parity bit.
// - One or two stop bits, applied to every transmitted character.
// - Length_five with two stop bits gives a 1.5 bit stop period.
// - Init applies the new line setup and empties both buffers.
// - User fills the transmit buffer, then write sends that many bytes.
// - Transmit idle flag is 0 while sending, back to 1 when all sent.
// - Write during an active transmission starts nothing and reports busy.
// - Write command answers at once; bytes keep shifting out afterwards.
// - Received bytes go to a circular FIFO; dequeue returns one, oldest first.
// - Data-ready flag is set while the receive FIFO holds unread bytes.
// - Dequeue on an empty FIFO reports no-data and leaves the FIFO unchanged.
// - Dequeued byte appears in first parameter register, result in result register.
// - Poll reports busy while transferring, otherwise the idle code.
// - Out-of-range parameter means no operation and result 0x02; success is 0x00.
// - Busy result is 0x01, meaning the serial interface is still transferring.
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module buffered_uart (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [buffered_uart_pkg::ADDR_W-1:0] paddr,
  input wire logic [buffered_uart_pkg::DATA_W-1:0] pwdata,
  output logic [buffered_uart_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_in,
  output logic serial_out
);
  import buffered_uart_pkg::*;

  // Parity of the low bits selected by the length code
  function automatic logic parity_of(input logic [7:0] d, input logic [2:0] lenc,
                                     input logic [2:0] mode);
    logic [7:0] m;
    logic x;
    m = d & (8'hFF >> (3'h3 - lenc));
    x = ^m;
    case (mode)
      PARITY_ODD: parity_of = ~x;
      PARITY_EVEN: parity_of = x;
      PARITY_MARK: parity_of = 1'b1;
      default: parity_of = 1'b0;
    endcase
  endfunction

  // Staged setup, applied only by init
  logic [31:0] baud_stage;
  logic [9:0] line_stage;
  logic [17:0] act_baud;
  logic [2:0] act_len;
  logic [2:0] act_par;
  logic [1:0] act_stop;
  logic [7:0] result;
  logic [7:0] param1;
  logic [7:0] tx_mem [TX_DEPTH];
  logic [7:0] rx_mem [RX_DEPTH];
  logic [RX_AW-1:0] rx_wr_ptr;
  logic [RX_AW-1:0] rx_rd_ptr;
  logic [RX_AW:0] rx_count;
  logic overrun;
  logic parity_err;
  logic frame_err;
  logic [24:0] tick_acc;
  tx_state_t tx_state;
  tx_state_t next_tx_state;
  logic [4:0] tx_tick;
  logic [2:0] tx_bit;
  logic [TX_AW-1:0] tx_idx;
  logic [5:0] tx_left;
  rx_state_t rx_state;
  rx_state_t next_rx_state;
  logic [4:0] rx_tick;
  logic [2:0] rx_bit;
  logic [7:0] rx_shift;
  logic [7:0] next_result;
  logic tx_line;

  // Bus decode
  wire wr_en = psel & penable & pwrite;
  wire rd_setup = psel & ~penable & ~pwrite;
  wire txbuf_hit = (paddr[11:7] == TXBUF_PAGE);
  wire [TX_AW-1:0] txbuf_idx = paddr[6:2];
  wire mapped = txbuf_hit || paddr == ADDR_BAUD || paddr == ADDR_LINE ||
                paddr == ADDR_COMMAND || paddr == ADDR_RESULT ||
                paddr == ADDR_PARAM1 || paddr == ADDR_FLAGS;
  wire cmd_fire = wr_en && paddr == ADDR_COMMAND;
  wire flags_wr = wr_en && paddr == ADDR_FLAGS;
  wire txbuf_wr = wr_en && txbuf_hit;
  wire [2:0] opcode = pwdata[OP_LSB +: 3];
  wire [7:0] cmd_count = pwdata[CNT_LSB +: 8];

  // Parameter checks on the staged setup and the write count
  wire [2:0] stg_len = line_stage[LEN_LSB +: 3];
  wire [2:0] stg_par = line_stage[PAR_LSB +: 3];
  wire [1:0] stg_stop = line_stage[STOP_LSB +: 2];
  wire baud_ok = baud_stage >= BAUD_MIN && baud_stage <= BAUD_MAX;
  wire len_ok = stg_len <= length_eight;
  wire par_ok = stg_par <= PARITY_SPACE;
  wire stop_ok = stg_stop <= STOP_TWO;
  wire cfg_ok = baud_ok && len_ok && par_ok && stop_ok;
  wire count_ok = cmd_count != 8'h00 && cmd_count <= 8'(TX_DEPTH);

  // Status terms
  wire tx_busy = tx_state != TX_IDLE;
  wire rx_empty = rx_count == '0;
  wire rx_full = rx_count == (RX_AW+1)'(RX_DEPTH);

  // Command effects; a rejected command touches nothing
  wire init_go = cmd_fire && opcode == OP_INIT && cfg_ok;
  wire write_go = cmd_fire && opcode == OP_WRITE && !tx_busy && count_ok;
  wire deq_go = cmd_fire && opcode == OP_DEQUEUE && !rx_empty;

  // Result code of the command being issued
  always_comb begin
    case (opcode)
      OP_INIT: next_result = cfg_ok ? result_ok : result_bad_parameter;
      OP_WRITE: next_result = tx_busy ? result_transferring :
                              (count_ok ? result_ok : result_bad_parameter);
      OP_DEQUEUE: next_result = rx_empty ? result_fifo_empty : result_ok;
      OP_POLL: next_result = tx_busy ? result_transferring : result_line_idle;
      default: next_result = result_bad_parameter;
    endcase
  end

  // Result and parameter registers; a write answers without waiting for the line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result <= result_ok;
      param1 <= 8'h00;
    end else if (cmd_fire) begin
      result <= next_result;
      if (deq_go) begin
        param1 <= rx_mem[rx_rd_ptr];
      end
    end
  end

  // Software-written setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_stage <= BAUD_RESET;
      line_stage <= LINE_RESET;
    end else if (wr_en && paddr == ADDR_BAUD) begin
      baud_stage <= pwdata;
    end else if (wr_en && paddr == ADDR_LINE) begin
      line_stage <= pwdata[9:0];
    end
  end

  // Active setup is shared by both directions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_baud <= BAUD_RESET[17:0];
      act_len <= LINE_RESET[LEN_LSB +: 3];
      act_par <= LINE_RESET[PAR_LSB +: 3];
      act_stop <= LINE_RESET[STOP_LSB +: 2];
    end else if (init_go) begin
      act_baud <= baud_stage[17:0];
      act_len <= stg_len;
      act_par <= stg_par;
      act_stop <= stg_stop;
    end
  end

  // Fractional tick generator at 16x the bit rate; avoids a hardware divider
  wire [24:0] tick_sum = tick_acc + {3'h0, act_baud, 4'h0};
  wire tick = tick_sum >= CLK_HZ;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_acc <= '0;
    end else if (init_go) begin
      tick_acc <= '0;
    end else begin
      tick_acc <= tick ? tick_sum - CLK_HZ : tick_sum;
    end
  end

  // Transmit buffer; contents must stay put while a write runs
  genvar gi;
  generate
    for (gi = 0; gi < TX_DEPTH; gi++) begin : g_txbuf
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          tx_mem[gi] <= 8'h00;
        end else if (init_go) begin
          tx_mem[gi] <= 8'h00;
        end else if (txbuf_wr && txbuf_idx == TX_AW'(gi)) begin
          tx_mem[gi] <= pwdata[7:0];
        end
      end
    end
  endgenerate

  // Transmit timing
  wire [2:0] last_bit = act_len + 3'h4;
  wire par_en = act_par != PARITY_NONE;
  wire [4:0] stop_last = act_stop != STOP_TWO ? TICK_BIT_LAST :
                         (act_len == length_five ? TICK_STOP_HALF_LAST :
                          TICK_STOP_TWO_LAST);
  wire [4:0] tx_tick_last = tx_state == TX_STOP ? stop_last : TICK_BIT_LAST;
  wire tx_end = tick && tx_tick == tx_tick_last;
  wire [7:0] tx_byte = tx_mem[tx_idx];
  wire tx_par = parity_of(tx_byte, act_len, act_par);

  // Transmit sequencing
  always_comb begin
    next_tx_state = tx_state;
    case (tx_state)
      TX_IDLE: if (write_go) next_tx_state = TX_START;
      TX_START: if (tx_end) next_tx_state = TX_DATA;
      TX_DATA: if (tx_end && tx_bit == last_bit) begin
        next_tx_state = par_en ? TX_PARITY : TX_STOP;
      end
      TX_PARITY: if (tx_end) next_tx_state = TX_STOP;
      TX_STOP: if (tx_end) begin
        next_tx_state = tx_left == 6'h01 ? TX_IDLE : TX_START;
      end
      default: next_tx_state = TX_IDLE;
    endcase
  end

  // Line level per state, one cycle behind the state for a glitch-free pin
  always_comb begin
    case (tx_state)
      TX_START: tx_line = 1'b0;
      TX_DATA: tx_line = tx_byte[tx_bit];
      TX_PARITY: tx_line = tx_par;
      default: tx_line = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state <= TX_IDLE;
      tx_tick <= '0;
      tx_bit <= '0;
      tx_idx <= '0;
      tx_left <= '0;
      serial_out <= 1'b1;
    end else begin
      tx_state <= init_go ? TX_IDLE : next_tx_state;
      tx_tick <= (tx_end || tx_state == TX_IDLE) ? 5'h00 : tx_tick + {4'h0, tick};
      tx_bit <= tx_state != TX_DATA ? 3'h0 : tx_bit + {2'h0, tx_end};
      serial_out <= tx_line;
      if (write_go) begin
        tx_idx <= '0;
        tx_left <= cmd_count[5:0];
      end else if (tx_state == TX_STOP && tx_end) begin
        tx_idx <= tx_idx + 1'b1;
        tx_left <= tx_left - 1'b1;
      end
    end
  end

  // Receive timing: first check at mid start bit, then one bit period apart
  wire [4:0] rx_tick_last = rx_state == RX_START ? TICK_MID : TICK_BIT_LAST;
  wire rx_end = tick && rx_tick == rx_tick_last;
  wire [7:0] rx_aligned = rx_shift >> (3'h3 - act_len);
  wire rx_push = rx_state == RX_STOP && rx_end && serial_in;
  wire push_ok = rx_push && !rx_full;
  wire par_bad = rx_state == RX_PARITY && rx_end &&
                 serial_in != parity_of(rx_aligned, act_len, act_par);
  wire frame_bad = rx_state == RX_STOP && rx_end && !serial_in;

  // Receive sequencing; a start that is not low at mid-bit is a glitch
  always_comb begin
    next_rx_state = rx_state;
    case (rx_state)
      RX_IDLE: if (tick && !serial_in) next_rx_state = RX_START;
      RX_START: if (rx_end) next_rx_state = serial_in ? RX_IDLE : RX_DATA;
      RX_DATA: if (rx_end && rx_bit == last_bit) begin
        next_rx_state = par_en ? RX_PARITY : RX_STOP;
      end
      RX_PARITY: if (rx_end) next_rx_state = RX_STOP;
      RX_STOP: if (rx_end) next_rx_state = RX_IDLE;
      default: next_rx_state = RX_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state <= RX_IDLE;
      rx_tick <= '0;
      rx_bit <= '0;
      rx_shift <= 8'h00;
    end else begin
      rx_state <= init_go ? RX_IDLE : next_rx_state;
      rx_tick <= (rx_end || rx_state == RX_IDLE) ? 5'h00 : rx_tick + {4'h0, tick};
      rx_bit <= rx_state != RX_DATA ? 3'h0 : rx_bit + {2'h0, rx_end};
      if (rx_state == RX_DATA && rx_end) begin
        rx_shift <= {serial_in, rx_shift[7:1]};
      end
    end
  end

  // Receive FIFO storage
  generate
    for (gi = 0; gi < RX_DEPTH; gi++) begin : g_rxbuf
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rx_mem[gi] <= 8'h00;
        end else if (push_ok && rx_wr_ptr == RX_AW'(gi)) begin
          rx_mem[gi] <= rx_aligned;
        end
      end
    end
  endgenerate

  // Circular pointers; a byte landing on a full FIFO is dropped and flagged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_wr_ptr <= '0;
      rx_rd_ptr <= '0;
      rx_count <= '0;
    end else if (init_go) begin
      rx_wr_ptr <= '0;
      rx_rd_ptr <= '0;
      rx_count <= '0;
    end else begin
      rx_wr_ptr <= rx_wr_ptr + {{(RX_AW-1){1'b0}}, push_ok};
      rx_rd_ptr <= rx_rd_ptr + {{(RX_AW-1){1'b0}}, deq_go};
      rx_count <= rx_count + {{RX_AW{1'b0}}, push_ok} - {{RX_AW{1'b0}}, deq_go};
    end
  end

  // Sticky error flags, cleared by init or write-one; a new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun <= 1'b0;
      parity_err <= 1'b0;
      frame_err <= 1'b0;
    end else begin
      overrun <= (rx_push && rx_full) ||
                 (overrun && !init_go && !(flags_wr && pwdata[FLAG_OVERRUN]));
      parity_err <= par_bad ||
                    (parity_err && !init_go && !(flags_wr && pwdata[FLAG_PARITY_ERR]));
      frame_err <= frame_bad ||
                   (frame_err && !init_go && !(flags_wr && pwdata[FLAG_FRAME_ERR]));
    end
  end

  // Flag word
  wire [31:0] flags_word = {19'h0, rx_count, 3'h0, frame_err, parity_err, overrun,
                            !rx_empty,
                            !tx_busy};

  // Read selection, captured in the setup phase so the access phase sees a register
  wire [31:0] read_value =
    txbuf_hit ? {24'h0, tx_mem[txbuf_idx]} :
    paddr == ADDR_BAUD ? baud_stage :
    paddr == ADDR_LINE ? {22'h0, line_stage} :
    paddr == ADDR_RESULT ? {24'h0, result} :
    paddr == ADDR_PARAM1 ? {24'h0, param1} :
    paddr == ADDR_FLAGS ? flags_word : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= read_value;
    end
  end

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

endmodule

`default_nettype wire

// ---- buffered_uart_pkg.sv ----
package buffered_uart_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [11:0] ADDR_BAUD = 12'h000;
  localparam logic [11:0] ADDR_LINE = 12'h004;
  localparam logic [11:0] ADDR_COMMAND = 12'h008;
  localparam logic [11:0] ADDR_RESULT = 12'h00C;
  localparam logic [11:0] ADDR_PARAM1 = 12'h010;
  localparam logic [11:0] ADDR_FLAGS = 12'h014;
  localparam logic [4:0] TXBUF_PAGE = 5'h02; // Window 0x100..0x17F, one byte per word

  // Buffer sizes
  localparam int unsigned TX_DEPTH = 32;
  localparam int unsigned TX_AW = 5;
  localparam int unsigned RX_DEPTH = 16;
  localparam int unsigned RX_AW = 4;

  // Clock and legal bit-rate span, in bits per second
  localparam logic [24:0] CLK_HZ = 25'h098_9680; // 10 MHz
  localparam logic [31:0] BAUD_MIN = 32'h0000_2580; // 9600
  localparam logic [31:0] BAUD_MAX = 32'h0003_8400; // 230400
  localparam logic [31:0] BAUD_RESET = 32'h0000_2580;

  // Oversampling: 16 ticks per bit
  localparam logic [4:0] TICK_MID = 5'h07;
  localparam logic [4:0] TICK_BIT_LAST = 5'h0F;
  localparam logic [4:0] TICK_STOP_HALF_LAST = 5'h17; // 1.5 bit times
  localparam logic [4:0] TICK_STOP_TWO_LAST = 5'h1F;

  // Line configuration fields
  localparam int unsigned LEN_LSB = 0;
  localparam int unsigned PAR_LSB = 4;
  localparam int unsigned STOP_LSB = 8;
  localparam logic [9:0] LINE_RESET = 10'h003;
  localparam logic [2:0] length_five = 3'h0;
  localparam logic [2:0] length_six = 3'h1;
  localparam logic [2:0] length_seven = 3'h2;
  localparam logic [2:0] length_eight = 3'h3;
  localparam logic [2:0] PARITY_NONE = 3'h0;
  localparam logic [2:0] PARITY_ODD = 3'h1;
  localparam logic [2:0] PARITY_EVEN = 3'h2;
  localparam logic [2:0] PARITY_MARK = 3'h3;
  localparam logic [2:0] PARITY_SPACE = 3'h4;
  localparam logic [1:0] STOP_ONE = 2'h0;
  localparam logic [1:0] STOP_TWO = 2'h1;

  // Command word fields and opcodes
  localparam int unsigned OP_LSB = 0;
  localparam int unsigned CNT_LSB = 8;
  localparam logic [2:0] OP_INIT = 3'h1;
  localparam logic [2:0] OP_WRITE = 3'h2;
  localparam logic [2:0] OP_DEQUEUE = 3'h3;
  localparam logic [2:0] OP_POLL = 3'h4;

  // Result codes
  localparam logic [7:0] result_ok = 8'h00;
  localparam logic [7:0] result_transferring = 8'h01;
  localparam logic [7:0] result_bad_parameter = 8'h02;
  localparam logic [7:0] result_line_idle = 8'h30;
  localparam logic [7:0] result_fifo_empty = 8'h31;

  // Flag register bit positions
  localparam int unsigned FLAG_TX_IDLE = 0;
  localparam int unsigned FLAG_RX_READY = 1;
  localparam int unsigned FLAG_OVERRUN = 2;
  localparam int unsigned FLAG_PARITY_ERR = 3;
  localparam int unsigned FLAG_FRAME_ERR = 4;
  localparam int unsigned FLAG_COUNT_LSB = 8;

  typedef enum logic [4:0] {
    TX_IDLE = 5'h01,
    TX_START = 5'h02,
    TX_DATA = 5'h04,
    TX_PARITY = 5'h08,
    TX_STOP = 5'h10
  } tx_state_t;

  typedef enum logic [4:0] {
    RX_IDLE = 5'h01,
    RX_START = 5'h02,
    RX_DATA = 5'h04,
    RX_PARITY = 5'h08,
    RX_STOP = 5'h10
  } rx_state_t;

endpackage

// ---- buffered_uart_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module buffered_uart_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [buffered_uart_pkg::ADDR_W-1:0] paddr,
  input wire logic [buffered_uart_pkg::DATA_W-1:0] pwdata,
  input wire logic [buffered_uart_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_in,
  input wire logic serial_out
);
  import buffered_uart_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Own copy of the map, so a decoder slip in the slave is seen
  wire logic mapped = paddr[1:0] == 2'h0 && (paddr < 12'h018 || paddr[11:7] == TXBUF_PAGE);
  wire logic access = psel && penable;
  logic prev_out;
  logic [7:0] run;
  wire logic level_change = serial_out != prev_out;
  // Length of the previous line level in clocks, saturating so idle never wraps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_out <= 1'b1;
      run <= 8'hFF;
    end else begin
      prev_out <= serial_out;
      run <= level_change ? 8'h01 : run + {7'h00, run != 8'hFF};
    end
  end
  // Register reads: setup on one address, then the access cycle
  sequence flags_read_s;
    psel && !penable && !pwrite && paddr == ADDR_FLAGS ##1 access;
  endsequence
  sequence busy_flags_read_s;
    psel && !penable && !pwrite && paddr == ADDR_FLAGS && !serial_out ##1 access;
  endsequence
  sequence result_read_s;
    psel && !penable && !pwrite && paddr == ADDR_RESULT ##1 access;
  endsequence
  sequence param_read_s;
    psel && !penable && !pwrite && paddr == ADDR_PARAM1 ##1 access;
  endsequence
  ready_always_a: assert property (access |-> pready)
    else $error("access phase without ready");
  unmapped_err_a: assert property (access && !mapped |-> pslverr)
    else $error("unmapped access without error");
  mapped_ok_a: assert property (access && mapped |-> !pslverr)
    else $error("error on a mapped address");
  unmapped_zero_a: assert property (access && !pwrite && !mapped |-> prdata == '0)
    else $error("unmapped read not zero");
  bit_width_a: assert property (level_change |-> run >= 8'h26)
    else $error("serial level shorter than the fastest bit");
  line_release_a: assert property ($rose(presetn) |-> serial_out)
    else $error("serial line not idle high after reset");
  busy_flag_a: assert property (busy_flags_read_s |-> !prdata[FLAG_TX_IDLE])
    else $error("idle flag set while a frame is on the line");
  rx_ready_count_a: assert property (flags_read_s |->
    prdata[FLAG_RX_READY] == (prdata[12:8] != 5'h00) && prdata[12:8] <= 5'h10)
    else $error("data ready flag disagrees with fifo count");
  result_code_a: assert property (result_read_s |-> prdata inside {result_ok,
    result_transferring, result_bad_parameter, result_line_idle, result_fifo_empty})
    else $error("unknown result code");
  param_width_a: assert property (param_read_s |-> prdata[31:8] == 24'h0)
    else $error("parameter register upper bits set");
endmodule
bind buffered_uart buffered_uart_props u_buffered_uart_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_in(serial_in),
  .serial_out(serial_out));
`default_nettype wire

// ---- serial_peer.sv ----
`timescale 1ns/1ps
`default_nettype none
module serial_peer #(
  parameter real BIT_NS = 4340.28
) (
  input wire logic [3:0] rx_n,
  input wire logic serial_out,
  output logic serial_in
);
  logic [10:0] frames[$];
  realtime starts[$];
  logic [10:0] f;
  initial serial_in = 1'b1;
  // Mid-bit sampling; stops after the first stop bit so a back-to-back start is caught
  always begin
    @(negedge serial_out);
    starts.push_back($realtime);
    f = '0;
    #(BIT_NS / 2);
    for (int k = 0; k < rx_n; k++) begin
      #(BIT_NS);
      f[k] = serial_out;
    end
    frames.push_back(f);
  end
  // Low start bit, then the given bits; gap sets how slowly the next one follows
  task automatic send(input logic [10:0] fr, input int n, input int gap);
    #(BIT_NS / 8);
    serial_in = 1'b0;
    #(BIT_NS);
    for (int k = 0; k < n; k++) begin
      serial_in = fr[k];
      #(BIT_NS);
    end
    serial_in = 1'b1;
    #(gap * BIT_NS);
  endtask
endmodule
`default_nettype wire

// ---- buffered_uart_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module buffered_uart_tb;
  import buffered_uart_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serial_in, serial_out, err, stp;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, q;
  logic [3:0] rx_n;
  logic [2:0] len, par;
  logic [7:0] b[3];
  logic [10:0] f;
  int num_errors, n_checks, nb;
  real span;
  buffered_uart u_buffered_uart (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_in(serial_in), .serial_out(serial_out));
  serial_peer u_serial_peer (.rx_n(rx_n), .serial_out(serial_out), .serial_in(serial_in));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Hard stop well past the expected run length
  initial begin
    #10000000;
    num_errors++;
    test_done();
  end
  task automatic test_done();
    if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask
  // Setup then access; request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      test_done();
    end
  endtask
  task automatic cmd(input logic [2:0] op, input logic [7:0] cnt, input logic [7:0] exp);
    apb(1'b1, ADDR_COMMAND, {16'h0000, cnt, 5'h00, op});
    apb(1'b0, ADDR_RESULT, 32'h0);
    check(q, {24'h0, exp});
  endtask
  // Polls the idle flag and leaves the transmit buffer alone meanwhile
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, ADDR_FLAGS, 32'h0);
      n++;
    end while (q[FLAG_TX_IDLE] !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      num_errors++;
      test_done();
    end
  endtask
  // Wire bits after the start bit, first stop included; n is their count
  function automatic logic [10:0] frame(input logic [7:0] d, input logic [2:0] l,
      input logic [2:0] p, output int n);
    logic [10:0] r;
    logic x;
    int w;
    r = '0;
    w = l + 5;
    for (int k = 0; k < w; k++) r[k] = d[k];
    x = ^r;
    if (p != PARITY_NONE) begin
      r[w] = (p == PARITY_ODD) ? ~x : (p == PARITY_EVEN) ? x : (p == PARITY_MARK);
      w++;
    end
    r[w] = 1'b1;
    n = w + 1;
    return r;
  endfunction
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    presetn = 1'b0;
    rx_n = 4'h9;
    num_errors = 0;
    n_checks = 0;
    q = $urandom(32'hDC5D);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_BAUD, 32'h0);
    check(q, BAUD_RESET);
    apb(1'b0, ADDR_LINE, 32'h0);
    check(q, {22'h0, LINE_RESET});
    apb(1'b0, ADDR_FLAGS, 32'h0);
    check(q, 32'h0000_0001);
    apb(1'b0, 12'h018, 32'h0);
    check({q[30:0], err}, 32'h0000_0001);
    // Rate just outside the span, bad length, parity and stop codes, then a good setup
    for (int j = 0; j < 6; j++) begin
      apb(1'b1, ADDR_BAUD, j == 0 ? 32'h0000_257F : j == 1 ? 32'h0003_8401 : BAUD_MAX);
      apb(1'b1, ADDR_LINE, j == 2 ? 32'h4 : j == 3 ? 32'h53 : j == 4 ? 32'h203 : 32'h3);
      cmd(OP_INIT, 8'h00, j == 5 ? result_ok : result_bad_parameter);
    end
    cmd(OP_WRITE, 8'h00, result_bad_parameter);
    cmd(OP_WRITE, 8'h21, result_bad_parameter);
    cmd(3'h0, 8'h00, result_bad_parameter);
    cmd(3'h7, 8'h00, result_bad_parameter);
    cmd(OP_DEQUEUE, 8'h00, result_fifo_empty);
    cmd(OP_POLL, 8'h00, result_line_idle);
    // Every length against every parity; the second half with two stop bits
    for (int i = 0; i < 20; i++) begin
      len = 3'(i % 4);
      par = 3'(i % 5);
      stp = i >= 10;
      apb(1'b1, ADDR_LINE, {22'h0, 1'b0, stp, 1'b0, par, 1'b0, len});
      cmd(OP_INIT, 8'h00, result_ok);
      apb(1'b0, ADDR_FLAGS, 32'h0);
      check(q & 32'h0000_1F1E, 32'h0);
      // Init must also have wiped what the previous pass left in the transmit buffer
      apb(1'b0, {TXBUF_PAGE, 5'h00, 2'h0}, 32'h0);
      check(q, 32'h0);
      f = frame(8'h00, len, par, nb);
      rx_n <= 4'(nb);
      u_serial_peer.frames.delete();
      u_serial_peer.starts.delete();
      for (int k = 0; k < 3; k++) begin
        b[k] = k == 0 ? {8{i[0]}} : 8'($urandom);
        apb(1'b1, {TXBUF_PAGE, 5'(k), 2'h0}, {24'h0, b[k]});
      end
      cmd(OP_WRITE, 8'h03, result_ok);
      apb(1'b0, ADDR_FLAGS, 32'h0);
      check({31'h0, q[FLAG_TX_IDLE]}, 32'h0);
      cmd(OP_WRITE, 8'h03, result_transferring);
      cmd(OP_POLL, 8'h00, result_transferring);
      wait_idle();
      cmd(OP_POLL, 8'h00, result_line_idle);
      check(32'(u_serial_peer.frames.size()), 32'h3);
      for (int k = 0; k < 3; k++) begin
        f = frame(b[k], len, par, nb);
        check({21'h0, u_serial_peer.frames[k]}, {21'h0, f});
      end
      span = (u_serial_peer.starts[2] - u_serial_peer.starts[1]) / 4340.28 - nb - 1;
      check(32'(int'(span * 4.0)), stp ? (len == length_five ? 32'h2 : 32'h4) : 32'h0);
      // Peer answers back to back first, then more slowly
      for (int k = 0; k < 3; k++) begin
        b[k] = 8'($urandom);
        f = frame(b[k], len, par, nb);
        u_serial_peer.send(f, nb, k);
      end
      apb(1'b0, ADDR_FLAGS, 32'h0);
      check(q & 32'h0000_1F1E, 32'h0000_0302);
      for (int k = 0; k < 3 - i % 2; k++) begin
        cmd(OP_DEQUEUE, 8'h00, result_ok);
        apb(1'b0, ADDR_PARAM1, 32'h0);
        check(q, {24'h0, b[k] & (8'hFF >> (3'h3 - len))});
      end
      // Odd passes leave a byte behind for the next setup to discard
      if (i % 2 == 0) begin
        cmd(OP_DEQUEUE, 8'h00, result_fifo_empty);
        apb(1'b0, ADDR_FLAGS, 32'h0);
        check(q & 32'h0000_1F1E, 32'h0);
      end
    end
    test_done();
  end
endmodule
`default_nettype wire
